// ### pct_pkg.sv
`default_nettype none

package pct_pkg;

  // ----------------------------------------------------------------
  // Data and bus widths
  // ----------------------------------------------------------------
  localparam int          DATA_W            = 32;
  localparam int          IDX_W             = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_REF_CONF      = 8'h01;
  localparam logic [7:0]  IDX_COMP_VALUE    = 8'h32;
  localparam logic [7:0]  IDX_RAMP_MODE     = 8'h40;
  localparam logic [7:0]  IDX_ACTUAL        = 8'h41;
  localparam logic [7:0]  IDX_TARGET        = 8'h42;
  localparam logic [7:0]  IDX_STEP_PERIOD   = 8'h43;
  localparam logic [7:0]  IDX_FLAGS         = 8'h44;
  localparam logic [7:0]  IDX_EVENTS        = 8'h45;
  localparam logic [7:0]  IDX_MASK          = 8'h46;

  // ----------------------------------------------------------------
  // Field positions in reference_configuration and ramp mode
  // ----------------------------------------------------------------
  localparam int          RC_OUT_SEL_LSB    = 0;
  localparam int          RC_CMP_SRC_BIT    = 2;
  localparam int          RC_CMP_MODE_LSB   = 3;
  localparam int          RC_CLR_TGT_BIT    = 5;
  localparam int          RAMP_POS_BIT      = 2;

  // ----------------------------------------------------------------
  // Flag and event bit positions
  // ----------------------------------------------------------------
  localparam int          EV_POS_COMP       = 0;
  localparam int          EV_TARGET         = 1;
  localparam int          FL_TARGET         = 0;
  localparam int          FL_VELOCITY       = 1;
  localparam int          FL_ENC_FAIL       = 2;
  localparam int          FL_POS_COMP       = 3;

  // ----------------------------------------------------------------
  // Output select and compare mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  OSEL_TARGET       = 2'h0;
  localparam logic [1:0]  OSEL_VELOCITY     = 2'h1;
  localparam logic [1:0]  OSEL_ENC_FAIL     = 2'h2;
  localparam logic [1:0]  OSEL_POS_COMP     = 2'h3;
  localparam logic [1:0]  CMODE_VALUE       = 2'h0;
  localparam logic [1:0]  CMODE_HOME        = 2'h1;
  localparam logic [1:0]  CMODE_LATCH       = 2'h2;
  localparam logic [1:0]  CMODE_REV         = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and bus responses
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO          = 32'h0000_0000;
  localparam logic [31:0] RST_STEP_PERIOD   = 32'h0000_000A;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

endpackage : pct_pkg

`default_nettype wire

// ### pct_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries compare settings, positions and flags between the block parts
interface pct_cmp_if;
  logic [1:0]  cmp_mode;
  logic        cmp_src;
  logic [31:0] actual_position;
  logic [31:0] encoder_position;
  logic [31:0] compare_value;
  logic [31:0] home_position;
  logic [31:0] actual_latched_position;
  logic [31:0] encoder_latched_position;
  logic [31:0] revolution_counter;
  logic        match_flag;
  logic        match_event;
  logic [1:0]  out_sel;
  logic        target_flag;
  logic        velocity_flag;
  logic        encoder_failure_flag;
  logic        pin_level;

  modport top  (output cmp_mode, cmp_src, actual_position, encoder_position, compare_value,
                home_position, actual_latched_position, encoder_latched_position,
                revolution_counter, out_sel, target_flag, velocity_flag,
                encoder_failure_flag,
                input  match_flag, match_event, pin_level);
  modport cmp  (input  cmp_mode, cmp_src, actual_position, encoder_position, compare_value,
                home_position, actual_latched_position, encoder_latched_position,
                revolution_counter,
                output match_flag, match_event);
  modport osel (input  out_sel, target_flag, velocity_flag, encoder_failure_flag, match_flag,
                output pin_level);
endinterface : pct_cmp_if

`default_nettype wire

// ### pct_comparator.sv
`timescale 1ns/1ps
`default_nettype none

module pct_comparator
  import pct_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  pct_cmp_if.cmp    cmp
);

  typedef struct packed {
    logic       flag;
    logic       evt;
    logic       below;
    logic [2:0] sel;
  } pct_cmp_state_t;

  pct_cmp_state_t s_r;
  pct_cmp_state_t s_nxt;
  logic [31:0]    lhs;
  logic [31:0]    rhs;

  // Pick the single pair of operands the selection asks for
  always_comb begin
    lhs = cmp.cmp_src ? cmp.encoder_position : cmp.actual_position;
    rhs = cmp.compare_value;
    case (cmp.cmp_mode)
      CMODE_HOME:  rhs = cmp.home_position;
      CMODE_LATCH: rhs = cmp.cmp_src ? cmp.encoder_latched_position
                                     : cmp.actual_latched_position;
      CMODE_REV:   lhs = cmp.revolution_counter;
      default:     rhs = cmp.compare_value;
    endcase
  end

  // Equality flag, match pulse and crossing detection, every cycle
  always_comb begin
    logic same_sel;
    logic enc_cross;
    same_sel      = (s_r.sel == {cmp.cmp_mode, cmp.cmp_src});
    s_nxt.sel     = {cmp.cmp_mode, cmp.cmp_src};
    s_nxt.below   = $signed(lhs) < $signed(rhs);
    s_nxt.flag    = (lhs == rhs);
    enc_cross     = same_sel && cmp.cmp_src && (cmp.cmp_mode != CMODE_REV)
                    && (lhs != rhs) && (s_r.below != s_nxt.below);
    s_nxt.evt     = (s_nxt.flag && !(s_r.flag && same_sel)) || enc_cross;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmp.match_flag  = s_r.flag;
  assign cmp.match_event = s_r.evt;

endmodule : pct_comparator

`default_nettype wire

// ### pct_out_select.sv
`timescale 1ns/1ps
`default_nettype none

module pct_out_select
  import pct_pkg::*;
(
  pct_cmp_if.osel sel
);

  // Route exactly one flag toward the target output pin
  always_comb begin
    case (sel.out_sel)
      OSEL_VELOCITY: sel.pin_level = sel.velocity_flag;
      OSEL_ENC_FAIL: sel.pin_level = sel.encoder_failure_flag;
      OSEL_POS_COMP: sel.pin_level = sel.match_flag;
      default:       sel.pin_level = sel.target_flag;
    endcase
  end

endmodule : pct_out_select

`default_nettype wire

// ### pct_top.sv
// How it works
// - Default output select drives the target pin from the target-hit flag.
// - Select codes 01/10/11 route velocity, encoder-failure, compare-match flag.
// - Comparator always runs and owns one match flag and one match event.
// - The match event can raise the interrupt output instead of the pin.
// - Source 0, basic mode: actual position against compare value.
// - Source 1, basic mode: encoder position against compare value.
// - Encoder position and compare value are both microsteps, compared unscaled.
// - Encoder passing the value without equality: event recorded, flag stays clear.
// - Mode 01 compares with home; mode 10 with the matching latch.
// - Mode 11 compares revolution counter with compare value, ignoring source.
// - Only the selected comparison may set the flag or raise the event.
// - In positioning mode the ramp ends when actual reaches target.
// - Clear-at-target zeroes actual on equality and restarts while target nonzero.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pct_top
  import pct_pkg::*;
#(
  parameter int ADDR_W = 10
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] encoder_position,
  input  wire logic [31:0] encoder_latched_position,
  input  wire logic [31:0] actual_latched_position,
  input  wire logic [31:0] home_position,
  input  wire logic [31:0] revolution_counter,
  input  wire logic        encoder_failure_flag,
  output logic             target_reached_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W must be between 9 and 16");
  end

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_idx;
    logic        aw_ok;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] ref_conf;
    logic [31:0] comp_value;
    logic [31:0] ramp_mode;
    logic [31:0] actual;
    logic [31:0] target;
    logic [31:0] step_period;
    logic [31:0] step_cnt;
    logic [1:0]  events;
    logic [1:0]  mask;
    logic        ramp_active;
    logic        target_flag;
    logic        velocity_flag;
    logic        pin;
    logic        irq;
  } pct_state_t;

  pct_state_t s_r;
  pct_state_t s_nxt;

  pct_cmp_if cif ();

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Merge written bytes into a register according to the strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // Word index of an aligned byte address; flags addresses beyond the index range
  function automatic logic [8:0] addr_to_idx(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = addr >> 2;
    return {(word > ADDR_W'(8'hFF)), word[7:0]};
  endfunction : addr_to_idx

  // True for an index that a register answers
  function automatic logic idx_mapped(input logic [7:0] idx);
    logic hit;
    if (idx == IDX_REF_CONF) begin
      hit = 1'b1;
    end else if (idx == IDX_COMP_VALUE) begin
      hit = 1'b1;
    end else if (idx >= IDX_RAMP_MODE && idx <= IDX_MASK) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction : idx_mapped

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------

  // Comparator settings, actual position and compare value come from registers; the other positions come straight from the inputs
  assign cif.cmp_mode                 = s_r.ref_conf[RC_CMP_MODE_LSB +: 2];
  assign cif.cmp_src                  = s_r.ref_conf[RC_CMP_SRC_BIT];
  assign cif.actual_position          = s_r.actual;
  assign cif.encoder_position         = encoder_position;
  assign cif.compare_value            = s_r.comp_value;
  assign cif.home_position            = home_position;
  assign cif.actual_latched_position  = actual_latched_position;
  assign cif.encoder_latched_position = encoder_latched_position;
  assign cif.revolution_counter       = revolution_counter;
  assign cif.out_sel                  = s_r.ref_conf[RC_OUT_SEL_LSB +: 2];
  assign cif.target_flag              = s_r.target_flag;
  assign cif.velocity_flag            = s_r.velocity_flag;
  assign cif.encoder_failure_flag     = encoder_failure_flag;

  pct_comparator u_cmp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cmp     (cif.cmp)
  );

  pct_out_select u_osel (
    .sel (cif.osel)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0]  widx;
    logic [8:0]  ridx;
    logic        do_write;
    logic        do_read;
    logic        at_target;
    logic        tick;
    logic [1:0]  ev_set;
    logic [1:0]  ev_clr;
    logic [31:0] rd;
    s_nxt    = s_r;
    widx     = addr_to_idx(s_axi_awaddr);
    ridx     = addr_to_idx(s_axi_araddr);
    ev_clr   = 2'h0;
    rd       = RST_ZERO;

    // Write address and data are taken independently
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.awready = 1'b0;
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_idx  = widx[7:0];
      s_nxt.aw_ok   = !widx[8] && idx_mapped(widx[7:0]);
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.wready = 1'b0;
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end
    do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    if (do_write) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = s_r.aw_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // Positioning ramp: step toward the target at the programmed rate
    at_target = (s_r.actual == s_r.target);
    // A period of 0 acts as 1; avoids the wrap of period minus one
    tick      = (s_r.step_cnt + 32'h0000_0001 >= s_r.step_period);
    s_nxt.step_cnt = tick ? RST_ZERO : s_r.step_cnt + 32'h0000_0001;
    if (s_r.ramp_mode[RAMP_POS_BIT]) begin
      if (at_target) begin
        if (s_r.ref_conf[RC_CLR_TGT_BIT]) begin
          s_nxt.actual      = RST_ZERO;
          s_nxt.ramp_active = (s_r.target != RST_ZERO);
        end else begin
          s_nxt.ramp_active = 1'b0;
        end
      end else begin
        s_nxt.ramp_active = 1'b1;
        if (tick) begin
          if ($signed(s_r.target) > $signed(s_r.actual)) begin
            s_nxt.actual = s_r.actual + 32'h0000_0001;
          end else begin
            s_nxt.actual = s_r.actual - 32'h0000_0001;
          end
        end
      end
    end else begin
      s_nxt.ramp_active = 1'b0;
    end

    // Flags follow the registered positions
    s_nxt.target_flag   = at_target;
    s_nxt.velocity_flag = s_r.ramp_active && !at_target;
    s_nxt.pin           = cif.pin_level;

    // Read path: register decode and read-clear of the events
    do_read = s_r.arready && s_axi_arvalid;
    if (ridx[8]) begin
      rd = RST_ZERO;
    end else if (ridx[7:0] == IDX_REF_CONF) begin
      rd = s_r.ref_conf;
    end else if (ridx[7:0] == IDX_COMP_VALUE) begin
      rd = s_r.comp_value;
    end else if (ridx[7:0] == IDX_RAMP_MODE) begin
      rd = s_r.ramp_mode;
    end else if (ridx[7:0] == IDX_ACTUAL) begin
      rd = s_r.actual;
    end else if (ridx[7:0] == IDX_TARGET) begin
      rd = s_r.target;
    end else if (ridx[7:0] == IDX_STEP_PERIOD) begin
      rd = s_r.step_period;
    end else if (ridx[7:0] == IDX_FLAGS) begin
      rd[FL_TARGET]   = s_r.target_flag;
      rd[FL_VELOCITY] = s_r.velocity_flag;
      rd[FL_ENC_FAIL] = encoder_failure_flag;
      rd[FL_POS_COMP] = cif.match_flag;
    end else if (ridx[7:0] == IDX_EVENTS) begin
      rd[1:0] = s_r.events;
      ev_clr  = do_read ? s_r.events : 2'h0;
    end else if (ridx[7:0] == IDX_MASK) begin
      rd[1:0] = s_r.mask;
    end
    if (do_read) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rdata   = rd;
      s_nxt.rresp   = (!ridx[8] && idx_mapped(ridx[7:0])) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Register writes; a write to the position overrides the ramp this cycle
    if (do_write && s_r.aw_ok) begin
      if (s_r.aw_idx == IDX_REF_CONF) begin
        s_nxt.ref_conf = apply_strb(s_r.ref_conf, s_r.wdata, s_r.wstrb);
      end else if (s_r.aw_idx == IDX_COMP_VALUE) begin
        s_nxt.comp_value = apply_strb(s_r.comp_value, s_r.wdata, s_r.wstrb);
      end else if (s_r.aw_idx == IDX_RAMP_MODE) begin
        s_nxt.ramp_mode = apply_strb(s_r.ramp_mode, s_r.wdata, s_r.wstrb);
      end else if (s_r.aw_idx == IDX_ACTUAL) begin
        s_nxt.actual = apply_strb(s_r.actual, s_r.wdata, s_r.wstrb);
      end else if (s_r.aw_idx == IDX_TARGET) begin
        s_nxt.target = apply_strb(s_r.target, s_r.wdata, s_r.wstrb);
      end else if (s_r.aw_idx == IDX_STEP_PERIOD) begin
        s_nxt.step_period = apply_strb(s_r.step_period, s_r.wdata, s_r.wstrb);
      end else if (s_r.aw_idx == IDX_MASK) begin
        s_nxt.mask = s_r.wdata[1:0];
      end
    end

    // Sticky events: a new event wins over the read-clear
    ev_set              = 2'h0;
    ev_set[EV_POS_COMP] = cif.match_event;
    ev_set[EV_TARGET]   = at_target && !s_r.target_flag;
    s_nxt.events        = (s_r.events & ~ev_clr) | ev_set;

    // Level interrupt from unmasked events
    s_nxt.irq = |(s_nxt.events & s_r.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r             <= '0;
      s_r.awready     <= 1'b1;
      s_r.wready      <= 1'b1;
      s_r.arready     <= 1'b1;
      s_r.step_period <= RST_STEP_PERIOD;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready      = s_r.awready;
  assign s_axi_wready       = s_r.wready;
  assign s_axi_bvalid       = s_r.bvalid;
  assign s_axi_bresp        = s_r.bresp;
  assign s_axi_arready      = s_r.arready;
  assign s_axi_rvalid       = s_r.rvalid;
  assign s_axi_rdata        = s_r.rdata;
  assign s_axi_rresp        = s_r.rresp;
  assign target_reached_out = s_r.pin;
  assign irq                = s_r.irq;

endmodule : pct_top

`default_nettype wire

// ### pct_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pct_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic        target_reached_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers stand until taken
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
  // Fixed answer latencies
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_write_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write late");
  // One access of each kind at a time
  a_read_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  a_write_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  a_rresp_legal: assert property (
    s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("bad rresp");
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !irq && !target_reached_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active in reset");
endmodule : pct_chk
bind pct_top pct_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .target_reached_out);
`default_nettype wire

// ### pct_host_mon.sv
`timescale 1ns/1ps
`default_nettype none
module pct_host_mon (
  input  wire logic aclk,
  input  wire logic irq,
  output int        n_irq
);
  logic irq_r;
  initial n_irq = 0;
  initial irq_r = 0;
  // Host counts each new interrupt request
  always @(posedge aclk) begin
    irq_r <= irq;
    if (irq && !irq_r) n_irq <= n_irq + 1;
  end
endmodule : pct_host_mon
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t bad value", $time); end end
module testbench;
  import pct_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, encoder_failure_flag, target_reached_out, irq;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rq, encoder_position, encoder_latched_position;
  logic [31:0] actual_latched_position, home_position, revolution_counter;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          n_fail, n_tests, n_irq, c, n0;
  pct_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .encoder_position,
    .encoder_latched_position, .actual_latched_position, .home_position, .revolution_counter,
    .encoder_failure_flag, .target_reached_out, .irq);
  pct_host_mon host (.aclk, .irq, .n_irq);
  // Clock of 100 ns
  always #50 aclk = ~aclk;
  task end_of_test;
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // One bus access, write or read
  task bus(input logic we, input logic [7:0] ix, input logic [31:0] d, input logic [3:0] st);
    logic ta, tw, tr, dn;
    int   k;
    dn = 0;
    @(posedge aclk);
    s_axi_awaddr  <= {ix, 2'h0};
    s_axi_araddr  <= {ix, 2'h0};
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= we;
    s_axi_wvalid  <= we;
    s_axi_bready  <= we;
    s_axi_arvalid <= !we;
    s_axi_rready  <= !we;
    for (k = 0; k < 40 && !dn; k++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      dn = we ? s_axi_bvalid : s_axi_rvalid;
      rq = s_axi_rdata;
      rs = we ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
    end
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    if (!dn) begin
      n_fail++;
      end_of_test;
    end
  endtask : bus
  task wr(input logic [7:0] ix, input logic [31:0] d);
    bus(1, ix, d, 4'hF);
  endtask : wr
  task rd(input logic [7:0] ix);
    bus(0, ix, 32'h0, 4'h0);
  endtask : rd
  task nx(input int n);
    repeat (n) @(negedge aclk);
  endtask : nx
  // Position inputs: all unequal to the operands, or a set at 5 except actual latch 7 and revolution counter 9
  task ops(input logic on);
    encoder_position         <= on ? 32'h5 : 32'h98;
    home_position            <= on ? 32'h5 : 32'h97;
    actual_latched_position  <= on ? 32'h7 : 32'h96;
    encoder_latched_position <= on ? 32'h5 : 32'h95;
    revolution_counter       <= on ? 32'h9 : 32'h94;
  endtask : ops
  task t_regs;
    rd(IDX_EVENTS);
    rd(IDX_STEP_PERIOD); `CHK(rq, RST_STEP_PERIOD)
    wr(IDX_COMP_VALUE, 32'h1234_5678); `CHK(rs, RESP_OKAY)
    bus(1, 8'h20, 32'h1, 4'hF); `CHK(rs, RESP_SLVERR)
    bus(1, IDX_COMP_VALUE, 32'hFFFF_FFFF, 4'h1);
    rd(IDX_COMP_VALUE); `CHK(rq, 32'h1234_56FF)
    rd(8'h20); `CHK({rs, rq}, {RESP_SLVERR, RST_ZERO})
  endtask : t_regs
  // Every mode and source pairing; bit index is {mode, source}
  task t_grid;
    logic [7:0] ex;
    ex = 8'h2F;
    wr(IDX_ACTUAL, 32'h5);
    for (c = 0; c < 8; c++) begin
      wr(IDX_REF_CONF, 32'(c) << RC_CMP_SRC_BIT);
      wr(IDX_COMP_VALUE, 32'h99);
      ops(0);
      nx(4);
      rd(IDX_EVENTS);
      ops(1);
      wr(IDX_COMP_VALUE, 32'h5);
      nx(4);
      rd(IDX_FLAGS); `CHK(rq[FL_POS_COMP], ex[c])
      rd(IDX_EVENTS); `CHK(rq[EV_POS_COMP], ex[c])
    end
  endtask : t_grid
  task t_cross;
    wr(IDX_REF_CONF, 32'h4);
    wr(IDX_COMP_VALUE, 32'h10);
    encoder_position <= 32'h0F;
    nx(4);
    rd(IDX_EVENTS);
    encoder_position <= 32'h11;
    nx(4);
    rd(IDX_FLAGS); `CHK(rq[FL_POS_COMP], 1'b0)
    rd(IDX_EVENTS); `CHK(rq[EV_POS_COMP], 1'b1)
  endtask : t_cross
  // Each select code routes its own flag to the pin
  task t_pin;
    logic [3:0] pe;
    wr(IDX_COMP_VALUE, 32'h5);
    encoder_failure_flag <= 1;
    for (n0 = 0; n0 < 2; n0++) begin
      if (n0 == 1) begin
        encoder_failure_flag <= 0;
        wr(IDX_TARGET, 32'h5);
        wr(IDX_COMP_VALUE, 32'h99);
      end
      pe = n0 ? 4'h1 : 4'hC;
      for (c = 0; c < 4; c++) begin
        wr(IDX_REF_CONF, 32'(c));
        nx(3); `CHK(target_reached_out, pe[c])
      end
    end
  endtask : t_pin
  task t_irq;
    wr(IDX_MASK, 32'h0);
    rd(IDX_EVENTS);
    n0 = n_irq;
    wr(IDX_COMP_VALUE, 32'h5);
    nx(4); `CHK(irq, 1'b0)
    wr(IDX_MASK, 32'h1);
    nx(3); `CHK(irq, 1'b1)
    `CHK(n_irq, n0 + 1)
    rd(IDX_EVENTS);
    nx(3); `CHK(irq, 1'b0)
  endtask : t_irq
  task t_ramp;
    wr(IDX_ACTUAL, 32'h0);
    wr(IDX_TARGET, 32'h3);
    wr(IDX_STEP_PERIOD, 32'h1);
    wr(IDX_RAMP_MODE, 32'h4);
    nx(30);
    rd(IDX_ACTUAL); `CHK(rq, 32'h3)
    rd(IDX_EVENTS);
    nx(20);
    rd(IDX_EVENTS); `CHK(rq[EV_TARGET], 1'b0)
    wr(IDX_REF_CONF, 32'h20);
    nx(20);
    rd(IDX_EVENTS); `CHK(rq[EV_TARGET], 1'b1)
    wr(IDX_TARGET, 32'h100);
    rd(IDX_FLAGS); `CHK(rq[FL_VELOCITY], 1'b1)
    wr(IDX_REF_CONF, 32'h21);
    nx(3); `CHK(target_reached_out, 1'b1)
  endtask : t_ramp
  // Reset, then the scenarios in turn
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, encoder_failure_flag, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 0;
    s_axi_wdata = 0;
    n_fail = 0;
    n_tests = 0;
    ops(0);
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_grid;
    t_cross;
    t_pin;
    t_irq;
    t_ramp;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
